/* ncocal_pkg.sv */
`default_nettype none
package ncocal_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [9:0]  IDX_REV       = 10'h297;
    localparam logic [9:0]  IDX_CAL_EN    = 10'h2B0;
    localparam logic [9:0]  IDX_CAL_CFG   = 10'h2B1;
    localparam logic [9:0]  IDX_CAL_RES   = 10'h2B2;
    localparam logic [9:0]  IDX_MAN_DLY   = 10'h2B5;
    localparam logic [9:0]  IDX_RAMP      = 10'h2B8;
    localparam logic [9:0]  IDX_CAL_HI    = 10'h2BF;
    localparam logic [9:0]  IDX_FREQ      = 10'h300;
    localparam logic [9:0]  IDX_PHASE     = 10'h308;
    localparam logic [9:0]  IDX_IRQ_STAT  = 10'h310;
    localparam logic [9:0]  IDX_IRQ_MASK  = 10'h311;
    localparam logic [9:0]  IDX_PRESET    = 10'h312;

    // Reset values
    localparam logic [7:0]  RST_CAL_EN    = 8'h00;
    localparam logic [7:0]  RST_CAL_CFG   = 8'h05;
    localparam logic [23:0] RST_MAN_DLY   = 24'h000000;
    localparam logic [7:0]  RST_RAMP      = 8'h00;
    localparam logic [31:0] RST_FREQ      = 32'hC0000000;
    localparam logic [15:0] RST_PHASE     = 16'h0000;
    localparam logic [3:0]  RST_PRESET    = 4'h0;
    // Arbitrary revision value
    localparam logic [4:0]  REV_ID        = 5'h0A;

    // Field positions and widths
    localparam int          CAL_EN_BIT    = 0;
    localparam int          RES_DONE_BIT  = 17;
    localparam int          DLY_W         = 17;
    localparam int          N_OSC         = 8;
    localparam int          EV_FREQ       = 0;
    localparam int          EV_CAL_DONE   = 1;
    localparam int          EV_CAL_BUSY   = 2;
    localparam int          EV_W          = 3;

    typedef enum logic {NCOCAL_IDLE, NCOCAL_ACK} ncocal_bus_t;

    // Byte-lane merge of write data into an old word
    function automatic logic [31:0] ncocal_merge(input logic [31:0] old_v,
                                                 input logic [31:0] wd,
                                                 input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : ncocal_merge
endpackage : ncocal_pkg
`default_nettype wire

/* ncocal_nco.sv */
`timescale 1ns/1ps
`default_nettype none
module ncocal_nco
    import ncocal_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        resync,
    input  wire logic [31:0] freq_word,
    input  wire logic [15:0] phase_word,
    output var  logic [31:0] phase_out
);
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [31:0] phase_r;
    logic [31:0] phase_nxt;

    always_comb begin
        // Link re-initialisation restores a known phase
        acc_nxt   = resync ? 32'h00000000 : acc_r + freq_word;
        // Offset sits in the upper half; modular add serves signed and unsigned alike
        phase_nxt = acc_r + {phase_word, 16'h0000};
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            acc_r   <= 32'h00000000;
            phase_r <= 32'h00000000;
        end else if (clk_en) begin
            acc_r   <= acc_nxt;
            phase_r <= phase_nxt;
        end
    end

    assign phase_out = phase_r;
endmodule : ncocal_nco
`default_nettype wire

/* ncocal_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module ncocal_regs
    import ncocal_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [11:0]      avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output var  logic [31:0]      avs_readdata,
    output var  logic             avs_waitrequest,
    input  wire logic             jesd_link_running,
    input  wire logic             nco_resync,
    input  wire logic             adc_cal_busy,
    input  wire logic             cal_done_in,
    input  wire logic [DLY_W-1:0] cal_delay_in,
    output var  logic             cal_start,
    output var  logic [7:0]       cal_config,
    output var  logic [7:0]       delay_ramp,
    output var  logic [DLY_W-1:0] aperture_delay,
    output var  logic [31:0]      osc_phase_a,
    output var  logic [31:0]      osc_phase_b,
    output var  logic             irq
);
    ncocal_bus_t       bus_st_r, bus_st_nxt;
    logic              wait_r, wait_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [31:0]       freq_r   [N_OSC];
    logic [31:0]       freq_nxt [N_OSC];
    logic [15:0]       phase_r  [N_OSC];
    logic [15:0]       phase_nxt[N_OSC];
    logic [7:0]        en_r, en_nxt;
    logic [7:0]        cfg_r, cfg_nxt;
    logic [23:0]       man_r, man_nxt;
    logic [7:0]        ramp_r, ramp_nxt;
    logic [3:0]        preset_r, preset_nxt;
    logic [EV_W-1:0]   stat_r, stat_nxt;
    logic [EV_W-1:0]   mask_r, mask_nxt;
    logic              irq_r, irq_nxt;
    logic              prev_en_r, prev_en_nxt;
    logic              start_r, start_nxt;
    logic              run_r, run_nxt;
    logic              done_r, done_nxt;
    logic [DLY_W-1:0]  res_r, res_nxt;
    logic [DLY_W-1:0]  dly_r, dly_nxt;
    logic [9:0]        idx;
    logic              wr_go;
    logic              cal_en;
    logic [EV_W-1:0]   ev;

    assign idx    = avs_address[11:2];
    assign cal_en = en_r[CAL_EN_BIT];
    // A write commits only at the edge where the master sees waitrequest low
    assign wr_go  = (bus_st_r == NCOCAL_ACK) && avs_write;

    // Bus slave: one wait cycle, then a one-cycle answer
    always_comb begin
        bus_st_nxt = bus_st_r;
        wait_nxt   = 1'b1;
        rdata_nxt  = rdata_r;
        unique case (bus_st_r)
            NCOCAL_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_st_nxt = NCOCAL_ACK;
                    wait_nxt   = 1'b0;
                    rdata_nxt  = 32'h00000000;
                    if (avs_read) begin
                        if (idx[9:3] == IDX_FREQ[9:3]) begin
                            rdata_nxt = freq_r[idx[2:0]];
                        end else if (idx[9:3] == IDX_PHASE[9:3]) begin
                            rdata_nxt = {16'h0000, phase_r[idx[2:0]]};
                        end else begin
                            // Reserved and unmapped words read zero
                            unique case (idx)
                                IDX_REV:      rdata_nxt = {27'h0000000, REV_ID};
                                IDX_CAL_EN:   rdata_nxt = {24'h000000, en_r};
                                IDX_CAL_CFG:  rdata_nxt = {24'h000000, cfg_r};
                                IDX_CAL_RES:  rdata_nxt = {14'h0000, done_r, res_r};
                                IDX_MAN_DLY:  rdata_nxt = {8'h00, man_r};
                                IDX_RAMP:     rdata_nxt = {24'h000000, ramp_r};
                                IDX_IRQ_STAT: rdata_nxt = {29'h00000000, stat_r};
                                IDX_IRQ_MASK: rdata_nxt = {29'h00000000, mask_r};
                                IDX_PRESET:   rdata_nxt = {28'h0000000, preset_r};
                                default:      rdata_nxt = 32'h00000000;
                            endcase
                        end
                    end
                end
            end
            NCOCAL_ACK: begin
                bus_st_nxt = NCOCAL_IDLE;
            end
        endcase
    end

    // Software-written registers
    always_comb begin
        en_nxt     = en_r;
        cfg_nxt    = cfg_r;
        man_nxt    = man_r;
        ramp_nxt   = ramp_r;
        preset_nxt = preset_r;
        mask_nxt   = mask_r;
        for (int i = 0; i < N_OSC; i++) begin
            freq_nxt[i]  = freq_r[i];
            phase_nxt[i] = phase_r[i];
        end
        if (wr_go) begin
            if (idx[9:3] == IDX_FREQ[9:3]) begin
                freq_nxt[idx[2:0]] = ncocal_merge(freq_r[idx[2:0]], avs_writedata, avs_byteenable);
            end else if (idx[9:3] == IDX_PHASE[9:3]) begin
                phase_nxt[idx[2:0]] = 16'(ncocal_merge({16'h0000, phase_r[idx[2:0]]},
                                                       avs_writedata, avs_byteenable));
            end else begin
                unique case (idx)
                    IDX_CAL_EN:   en_nxt     = 8'(ncocal_merge({24'h000000, en_r},
                                                               avs_writedata, avs_byteenable));
                    IDX_CAL_CFG:  cfg_nxt    = 8'(ncocal_merge({24'h000000, cfg_r},
                                                               avs_writedata, avs_byteenable));
                    IDX_MAN_DLY:  man_nxt    = 24'(ncocal_merge({8'h00, man_r},
                                                                avs_writedata, avs_byteenable));
                    IDX_RAMP:     ramp_nxt   = 8'(ncocal_merge({24'h000000, ramp_r},
                                                               avs_writedata, avs_byteenable));
                    IDX_IRQ_MASK: mask_nxt   = EV_W'(ncocal_merge({29'h00000000, mask_r},
                                                                  avs_writedata, avs_byteenable));
                    IDX_PRESET:   preset_nxt = 4'(ncocal_merge({28'h0000000, preset_r},
                                                               avs_writedata, avs_byteenable));
                    default:      ;
                endcase
            end
        end
    end

    // Calibration sequencing and delay selection
    always_comb begin
        prev_en_nxt = cal_en;
        // Only a fresh 0-to-1 change starts a sequence
        start_nxt   = cal_en && !prev_en_r;
        run_nxt     = run_r;
        done_nxt    = done_r;
        res_nxt     = res_r;
        if (start_r) begin
            run_nxt  = 1'b1;
            done_nxt = 1'b0;
        end else if (run_r && cal_done_in) begin
            run_nxt  = 1'b0;
            done_nxt = 1'b1;
            res_nxt  = cal_delay_in;
        end
        if (!en_nxt[CAL_EN_BIT]) begin
            // Cleared at the edge that clears the enable, so complete never reads 1 disabled
            run_nxt  = 1'b0;
            done_nxt = 1'b0;
        end
        // Manual delay when disabled, calibrated result when enabled
        dly_nxt = cal_en ? res_r : man_r[DLY_W-1:0];
    end

    // Sticky events; a new event wins over a same-cycle clear
    always_comb begin
        ev = '0;
        // Frequency change on a live link leaves the phase undefined
        ev[EV_FREQ]     = wr_go && (idx[9:3] == IDX_FREQ[9:3]) && jesd_link_running;
        ev[EV_CAL_DONE] = run_r && cal_done_in && cal_en;
        // Host should not start while converter calibration runs; flag it
        ev[EV_CAL_BUSY] = start_r && adc_cal_busy;
        stat_nxt = stat_r;
        if (wr_go && idx == IDX_IRQ_STAT && avs_byteenable[0]) begin
            stat_nxt = stat_r & ~avs_writedata[EV_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
        irq_nxt  = |(stat_r & mask_r);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bus_st_r  <= NCOCAL_IDLE;
            wait_r    <= 1'b1;
            rdata_r   <= 32'h00000000;
            en_r      <= RST_CAL_EN;
            cfg_r     <= RST_CAL_CFG;
            man_r     <= RST_MAN_DLY;
            ramp_r    <= RST_RAMP;
            preset_r  <= RST_PRESET;
            mask_r    <= '0;
            stat_r    <= '0;
            irq_r     <= 1'b0;
            prev_en_r <= 1'b0;
            start_r   <= 1'b0;
            run_r     <= 1'b0;
            done_r    <= 1'b0;
            res_r     <= '0;
            dly_r     <= '0;
            for (int i = 0; i < N_OSC; i++) begin
                freq_r[i]  <= RST_FREQ;
                phase_r[i] <= RST_PHASE;
            end
        end else if (clk_en) begin
            bus_st_r  <= bus_st_nxt;
            wait_r    <= wait_nxt;
            rdata_r   <= rdata_nxt;
            en_r      <= en_nxt;
            cfg_r     <= cfg_nxt;
            man_r     <= man_nxt;
            ramp_r    <= ramp_nxt;
            preset_r  <= preset_nxt;
            mask_r    <= mask_nxt;
            stat_r    <= stat_nxt;
            irq_r     <= irq_nxt;
            prev_en_r <= prev_en_nxt;
            start_r   <= start_nxt;
            run_r     <= run_nxt;
            done_r    <= done_nxt;
            res_r     <= res_nxt;
            dly_r     <= dly_nxt;
            for (int i = 0; i < N_OSC; i++) begin
                freq_r[i]  <= freq_nxt[i];
                phase_r[i] <= phase_nxt[i];
            end
        end
    end

    // Path A uses presets 0-3, path B presets 4-7
    ncocal_nco u_nco_a (
        .clock      (clock),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .resync     (nco_resync),
        .freq_word  (freq_r[{1'b0, preset_r[1:0]}]),
        .phase_word (phase_r[{1'b0, preset_r[1:0]}]),
        .phase_out  (osc_phase_a)
    );

    ncocal_nco u_nco_b (
        .clock      (clock),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .resync     (nco_resync),
        .freq_word  (freq_r[{1'b1, preset_r[3:2]}]),
        .phase_word (phase_r[{1'b1, preset_r[3:2]}]),
        .phase_out  (osc_phase_b)
    );

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign cal_start       = start_r;
    assign cal_config      = cfg_r;
    assign delay_ramp      = ramp_r;
    assign aperture_delay  = dly_r;
    assign irq             = irq_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence rev_read_s;
        avs_read && !avs_waitrequest && (idx == IDX_REV);
    endsequence
    sequence rsvd_read_s;
        avs_read && !avs_waitrequest && (idx > IDX_RAMP) && (idx <= IDX_CAL_HI);
    endsequence
    sequence cal_rise_s;
        clk_en && cal_en && !prev_en_r;
    endsequence

    rev_read_a: assert property (rev_read_s |-> avs_readdata == {27'h0000000, REV_ID})
        else $error("revision read returned wrong value");
    rsvd_read_a: assert property (rsvd_read_s |-> avs_readdata == 32'h00000000)
        else $error("reserved calibration word not zero");
    manual_delay_a: assert property (clk_en && !cal_en |=> aperture_delay == $past(man_r[DLY_W-1:0]))
        else $error("manual delay not applied");
    auto_delay_a: assert property (clk_en && cal_en |=> aperture_delay == $past(res_r))
        else $error("calibrated delay not applied");
    cal_launch_a: assert property (cal_rise_s |=> cal_start ##1 (!clk_en || !cal_start))
        else $error("calibration start pulse wrong");
    no_restart_a: assert property (clk_en && prev_en_r && cal_en |=> !cal_start)
        else $error("held enable restarted calibration");
    done_gated_a: assert property (done_r |-> cal_en)
        else $error("complete set while disabled");
    freq_event_a: assert property (clk_en && ev[EV_FREQ] |=> stat_r[EV_FREQ] ##1 (!clk_en || irq == mask_r[EV_FREQ] || irq))
        else $error("frequency change event lost");
endmodule : ncocal_regs
`default_nettype wire

/* test_ncocal_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ncocal_regs;
    import ncocal_pkg::*;

    logic             clock = 1'b0;
    logic             reset_n = 1'b0;
    logic             clk_en = 1'b1;
    logic [11:0]      avs_address = 12'h000;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h00000000;
    logic [3:0]       avs_byteenable = 4'hF;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             jesd_link_running = 1'b0;
    logic             nco_resync = 1'b0;
    logic             adc_cal_busy = 1'b0;
    logic             cal_done_in = 1'b0;
    logic [DLY_W-1:0] cal_delay_in = 17'h00000;
    logic             cal_start;
    logic [7:0]       cal_config;
    logic [7:0]       delay_ramp;
    logic [DLY_W-1:0] aperture_delay;
    logic [31:0]      osc_phase_a;
    logic [31:0]      osc_phase_b;
    logic             irq;
    int               n_mismatch = 0;
    int               num_checks = 0;
    int               n_start = 0;
    int               n_cycle = 0;
    logic [31:0]      rd;

    ncocal_regs dut_u (
        .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .jesd_link_running(jesd_link_running),
        .nco_resync(nco_resync), .adc_cal_busy(adc_cal_busy), .cal_done_in(cal_done_in),
        .cal_delay_in(cal_delay_in), .cal_start(cal_start), .cal_config(cal_config),
        .delay_ramp(delay_ramp), .aperture_delay(aperture_delay), .osc_phase_a(osc_phase_a),
        .osc_phase_b(osc_phase_b), .irq(irq)
    );

    always #2.5 clock = ~clock;

    // Pulses are counted at the edge so a held-high start shows up as extra counts
    always @(posedge clock) begin
        n_cycle++;
        if (cal_start === 1'b1) begin
            n_start++;
        end
        if (n_cycle > 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until waitrequest is sampled low; data taken at that same edge
    task automatic bus_wr(input logic [9:0] idx, input logic [31:0] d);
        @(posedge clock);
        avs_write     <= 1'b1;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [9:0] idx, output logic [31:0] d);
        @(posedge clock);
        avs_read    <= 1'b1;
        avs_address <= {idx, 2'b00};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_rd

    task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(idx, v);
        chk(what, exp, v);
    endtask : rd_chk

    task automatic test_end(input string name);
        $display("test %s done, mismatches so far %0d", name, n_mismatch);
    endtask : test_end

    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);

        rd_chk("enable reset", IDX_CAL_EN, 32'h00000000);
        rd_chk("config reset", IDX_CAL_CFG, 32'h00000005);
        rd_chk("manual reset", IDX_MAN_DLY, 32'h00000000);
        rd_chk("ramp reset", IDX_RAMP, 32'h00000000);
        rd_chk("freq b reset", IDX_FREQ + 10'h004, 32'hC0000000);
        bus_wr(IDX_REV, 32'hFFFFFFFF);
        rd_chk("revision", IDX_REV, 32'h0000000A);
        test_end("reset_values");

        bus_wr(IDX_CAL_HI - 10'h006, 32'h000000FF);
        rd_chk("reserved 2B9", IDX_CAL_HI - 10'h006, 32'h00000000);
        rd_chk("reserved 2BF", IDX_CAL_HI, 32'h00000000);
        rd_chk("reserved 2B3", IDX_CAL_RES + 10'h001, 32'h00000000);
        bus_wr(IDX_RAMP, 32'h000000A5);
        @(posedge clock);
        chk("ramp out", 32'h000000A5, {24'h0, delay_ramp});
        bus_wr(IDX_MAN_DLY, 32'h00FFFFFF);
        rd_chk("manual rb", IDX_MAN_DLY, 32'h00FFFFFF);
        repeat (2) @(posedge clock);
        chk("manual drives delay", 32'h0001FFFF, {15'h0, aperture_delay});
        test_end("address_map");

        bus_wr(IDX_IRQ_MASK, 32'h00000002);
        bus_wr(IDX_CAL_CFG, 32'h0000000A);
        @(posedge clock);
        chk("config out", 32'h0000000A, {24'h0, cal_config});
        bus_wr(IDX_CAL_EN, 32'h00000001);
        repeat (4) @(posedge clock);
        chk("one start pulse", 32'd1, n_start);
        bus_wr(IDX_CAL_EN, 32'h00000001);
        repeat (4) @(posedge clock);
        chk("held enable no restart", 32'd1, n_start);
        rd_chk("not complete", IDX_CAL_RES, 32'h00000000);
        @(posedge clock);
        cal_delay_in <= 17'h1ABCD;
        cal_done_in  <= 1'b1;
        @(posedge clock);
        cal_done_in  <= 1'b0;
        repeat (3) @(posedge clock);
        rd_chk("result", IDX_CAL_RES, 32'h0003ABCD);
        chk("calibrated delay", 32'h0001ABCD, {15'h0, aperture_delay});
        bus_wr(IDX_MAN_DLY, 32'h00000123);
        repeat (2) @(posedge clock);
        chk("manual ignored", 32'h0001ABCD, {15'h0, aperture_delay});
        rd_chk("status done", IDX_IRQ_STAT, 32'h00000002);
        chk("irq unmasked", 32'h00000001, {31'h0, irq});
        bus_wr(IDX_IRQ_STAT, 32'h00000002);
        repeat (2) @(posedge clock);
        chk("irq cleared", 32'h00000000, {31'h0, irq});
        bus_wr(IDX_CAL_EN, 32'h00000000);
        bus_rd(IDX_CAL_RES, rd);
        chk("complete off", 32'h00000000, {31'h0, rd[RES_DONE_BIT]});
        repeat (2) @(posedge clock);
        chk("manual again", 32'h00000123, {15'h0, aperture_delay});
        test_end("calibration");

        adc_cal_busy <= 1'b1;
        bus_wr(IDX_IRQ_MASK, 32'h00000000);
        bus_wr(IDX_CAL_EN, 32'h00000001);
        repeat (4) @(posedge clock);
        chk("restart after zero", 32'd2, n_start);
        rd_chk("busy start status", IDX_IRQ_STAT, 32'h00000004);
        chk("irq masked", 32'h00000000, {31'h0, irq});
        bus_wr(IDX_IRQ_MASK, 32'h00000004);
        repeat (2) @(posedge clock);
        chk("irq busy", 32'h00000001, {31'h0, irq});
        adc_cal_busy <= 1'b0;
        bus_wr(IDX_IRQ_STAT, 32'h00000004);
        rd_chk("status clear", IDX_IRQ_STAT, 32'h00000000);
        test_end("interrupt");

        // Resync held high keeps the accumulators at zero so only the offset shows
        nco_resync        <= 1'b1;
        jesd_link_running <= 1'b1;
        bus_wr(IDX_FREQ, 32'h00000000);
        rd_chk("freq a rb", IDX_FREQ, 32'h00000000);
        rd_chk("freq change event", IDX_IRQ_STAT, 32'h00000001);
        bus_wr(IDX_PHASE, 32'h00008001);
        bus_wr(IDX_PHASE + 10'h004, 32'h00001234);
        repeat (4) @(posedge clock);
        chk("phase a", 32'h80010000, osc_phase_a);
        chk("phase b", 32'h12340000, osc_phase_b);
        bus_wr(IDX_PRESET, 32'h00000004);
        rd_chk("preset rb", IDX_PRESET, 32'h00000004);
        chk("phase b preset 5", 32'h00000000, osc_phase_b);
        bus_wr(IDX_PRESET, 32'h00000000);
        repeat (2) @(posedge clock);
        // Path A word is zero, path B keeps its reset word, so one step each is predictable
        nco_resync <= 1'b0;
        repeat (3) @(posedge clock);
        chk("phase a step", 32'h80010000, osc_phase_a);
        chk("phase b step", 32'hD2340000, osc_phase_b);
        clk_en <= 1'b0;
        repeat (3) @(posedge clock);
        chk("phase b frozen", 32'h92340000, osc_phase_b);
        clk_en <= 1'b1;
        jesd_link_running <= 1'b0;
        test_end("oscillator");

        end_of_test();
    end
endmodule : test_ncocal_regs
`default_nettype wire
